// *** design/bf_cfg.svh ***
// Constants for the breaker failure supervisor: offsets, fields, resets, timing
`ifndef BF_CFG_SVH
`define BF_CFG_SVH

// ****************************************************
// Register offsets (byte addresses)
// ****************************************************
`define BF_ADR_CTRL 8'h00
`define BF_ADR_TIME 8'h04
`define BF_ADR_STATUS 8'h08
`define BF_ADR_IRQ_STAT 8'h0C
`define BF_ADR_IRQ_MASK 8'h10
`define BF_ADR_ACK 8'h14

// ****************************************************
// Field positions
// ****************************************************
`define BF_CTRL_METHOD_LSB 0
`define BF_CTRL_CLASS_LSB 2
`define BF_CTRL_ENABLE_BIT 4
`define BF_ACK_LOCK_BIT 0
`define BF_IRQ_FAIL_BIT 0
`define BF_IRQ_REJECT_BIT 1
`define BF_IRQ_START_BIT 2
`define BF_IRQ_W 3

// ****************************************************
// Reset values
// ****************************************************
`define BF_CTRL_RST 5'h10
`define BF_TIME_RST 16'h0064
`define BF_MASK_RST 3'h0

// ****************************************************
// Timing
// ****************************************************
`define BF_CLK_MHZ 10
`define BF_TICK_US 1000
`define BF_TICK_CYC (`BF_TICK_US * `BF_CLK_MHZ)
`define BF_TIME_W 16
`define BF_DIV_W 24

`endif

// *** design/bf_open_detect.sv ***
// Breaker opening detection for the selected supervision method
`timescale 1ns/1ps
`default_nettype none

module bf_open_detect (
	// Settings
	input wire bf_pkg::method_t method,
	input wire logic freq_deviates,
	// Measurements
	input wire logic current_above,
	input wire logic position_open,
	// Results
	output logic opened,
	output logic blocked
);
	import bf_pkg::*;

	// ****************************************************
	// Opening judgement
	// ****************************************************
	always_comb begin
		opened = 1'b0;
		blocked = 1'b0;
		case (method)
			CURRENT_CHECK_METHOD: begin
				opened = !current_above;
				blocked = freq_deviates;
			end
			POSITION_CHECK_METHOD: begin
				opened = position_open;
			end
			COMBINED_CHECK_METHOD: begin
				if (freq_deviates) begin
					opened = position_open;
				end else begin
					opened = !current_above || position_open;
				end
			end
			default: begin
				blocked = 1'b1;
			end
		endcase
	end

endmodule : bf_open_detect
`default_nettype wire

// *** design/bf_pkg.sv ***
// Types shared by the breaker failure supervisor files
`default_nettype none

package bf_pkg;

	typedef enum logic [1:0] {
		CURRENT_CHECK_METHOD,
		POSITION_CHECK_METHOD,
		COMBINED_CHECK_METHOD,
		METHOD_SPARE
	} method_t;

	typedef enum logic [1:0] {
		CLASS_ALL,
		CLASS_EXTERNAL,
		CLASS_CURRENT,
		CLASS_NONE
	} trig_class_t;

	typedef enum {
		ST_STANDBY,
		ST_RUNNING,
		ST_REJECTED,
		ST_FAILED
	} state_t;

	typedef struct packed {
		logic trip_all;
		logic trip_ext;
		logic trip_cur;
		logic [2:0] extra_trigger_input;
		logic current_above;
		logic position_open;
		logic freq_deviates;
	} relay_in_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

endpackage : bf_pkg
`default_nettype wire

// *** design/bf_timer.sv ***
// Supervision timer with millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
`include "bf_cfg.svh"

module bf_timer #(
	parameter int unsigned TICK_CYC = `BF_TICK_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic run,
	input wire logic [`BF_TIME_W-1:0] limit,
	// Result
	output logic expired
);
	logic [`BF_DIV_W-1:0] div_q;
	logic [`BF_TIME_W-1:0] ms_q;
	logic tick;

	assign tick = (div_q == `BF_DIV_W'(TICK_CYC - 1));
	assign expired = run && (ms_q >= limit);

	// ****************************************************
	// Tick divider
	// ****************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else if (start || !run || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + `BF_DIV_W'(1);
		end
	end

	// ****************************************************
	// Elapsed milliseconds
	// ****************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_q <= '0;
		end else if (start || !run) begin
			ms_q <= '0;
		end else if (tick && ms_q != '1) begin
			ms_q <= ms_q + `BF_TIME_W'(1);
		end
	end

endmodule : bf_timer
`default_nettype wire

// *** design/breaker_failure_supervisor.sv ***
// Breaker failure supervisor with Wishbone registers and interrupt
// ****************************************************
// Summary of operation
// - Method selectable: current, position, or both
// - Current method: fail if current stays high
// - Position method: fail if not shown open
// - Combined: fail only if both show closed, at nominal frequency
// - Off-frequency blocks current, combined acts positional
// - Running timer ignores trigger drop
// - Expiry without opening raises upstream failure trip
// - Detected opening stops the timer
// - Opening with trigger still active: rejected
// - Triggers gone: rejected returns to stand-by
// - Lock with trip, cleared by acknowledge or reset
// - Trigger class: all, external, current, none
// - Three extra triggers bypass class selection
// ****************************************************
`timescale 1ns/1ps
`default_nettype none
`include "bf_cfg.svh"

module breaker_failure_supervisor #(
	parameter int unsigned TICK_CYC = `BF_TICK_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire bf_pkg::wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Relay signals
	input wire bf_pkg::relay_in_t relay_in,
	input wire logic hmi_ack,
	// Outputs
	output logic failure_trip,
	output logic lock,
	output logic irq
);
	import bf_pkg::*;

	// ****************************************************
	// Declarations
	// ****************************************************
	logic [4:0] ctrl_q;
	logic [`BF_TIME_W-1:0] time_q;
	logic [`BF_IRQ_W-1:0] irq_stat_q;
	logic [`BF_IRQ_W-1:0] irq_mask_q;
	logic [`BF_IRQ_W-1:0] irq_set;
	logic ack_q;
	logic [31:0] dat_q;
	logic wr_commit;
	logic [31:0] wr_word;
	logic [31:0] time_word;
	logic sw_ack;
	state_t state_q;
	state_t state_d;
	logic trip_q;
	logic lock_q;
	logic trig_q;
	logic trig_now;
	logic trig_rise;
	logic class_trig;
	logic opened;
	logic blocked;
	logic expired;
	logic start;
	logic run;
	method_t method;
	trig_class_t trig_class;
	logic enable;

	assign method = method_t'(ctrl_q[`BF_CTRL_METHOD_LSB +: 2]);
	assign trig_class = trig_class_t'(ctrl_q[`BF_CTRL_CLASS_LSB +: 2]);
	assign enable = ctrl_q[`BF_CTRL_ENABLE_BIT];

	// ****************************************************
	// Byte lane merge
	// ****************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ****************************************************
	// Wishbone handshake
	// ****************************************************
	assign wr_commit = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
		end
	end

	// ****************************************************
	// Read data
	// ****************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h00000000;
		end else if (wb_req.cyc && wb_req.stb && !ack_q) begin
			case (wb_req.adr)
				`BF_ADR_CTRL: dat_q <= {27'h0000000, ctrl_q};
				`BF_ADR_TIME: dat_q <= {16'h0000, time_q};
				`BF_ADR_STATUS: dat_q <= {16'h0000, 4'h0, relay_in.extra_trigger_input,
					relay_in.freq_deviates, relay_in.position_open,
					relay_in.current_above, trig_now, lock_q, trip_q,
					state_q == ST_FAILED, state_q == ST_REJECTED,
					state_q == ST_RUNNING};
				`BF_ADR_IRQ_STAT: dat_q <= {29'h00000000, irq_stat_q};
				`BF_ADR_IRQ_MASK: dat_q <= {29'h00000000, irq_mask_q};
				default: dat_q <= 32'h00000000;
			endcase
		end
	end

	// ****************************************************
	// Control and time registers
	// ****************************************************
	assign wr_word = merge({27'h0000000, ctrl_q}, wb_req.dat, wb_req.sel);
	assign time_word = merge({16'h0000, time_q}, wb_req.dat, wb_req.sel);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `BF_CTRL_RST;
		end else if (wr_commit && wb_req.adr == `BF_ADR_CTRL) begin
			ctrl_q <= wr_word[4:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			time_q <= `BF_TIME_RST;
		end else if (wr_commit && wb_req.adr == `BF_ADR_TIME) begin
			time_q <= time_word[15:0];
		end
	end

	assign sw_ack = wr_commit && wb_req.adr == `BF_ADR_ACK && wb_req.sel[0]
		&& wb_req.dat[`BF_ACK_LOCK_BIT];

	// ****************************************************
	// Trigger selection
	// ****************************************************
	always_comb begin
		case (trig_class)
			CLASS_ALL: class_trig = relay_in.trip_all;
			CLASS_EXTERNAL: class_trig = relay_in.trip_ext;
			CLASS_CURRENT: class_trig = relay_in.trip_cur;
			default: class_trig = 1'b0;
		endcase
	end

	assign trig_now = class_trig || (|relay_in.extra_trigger_input);
	assign trig_rise = trig_now && !trig_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= trig_now;
		end
	end

	// ****************************************************
	// Opening detection and timer
	// ****************************************************
	bf_open_detect u_detect (
		.method(method),
		.freq_deviates(relay_in.freq_deviates),
		.current_above(relay_in.current_above),
		.position_open(relay_in.position_open),
		.opened(opened),
		.blocked(blocked)
	);

	assign start = (state_q == ST_STANDBY) && enable && !blocked && trig_rise;
	assign run = (state_q == ST_RUNNING);

	bf_timer #(
		.TICK_CYC(TICK_CYC)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(start),
		.run(run),
		.limit(time_q),
		.expired(expired)
	);

	// ****************************************************
	// Supervision state machine
	// ****************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_STANDBY: begin
				if (start) begin
					state_d = ST_RUNNING;
				end
			end
			ST_RUNNING: begin
				if (blocked || !enable) begin
					state_d = ST_STANDBY;
				end else if (opened) begin
					state_d = trig_now ? ST_REJECTED : ST_STANDBY;
				end else if (expired) begin
					state_d = ST_FAILED;
				end
			end
			ST_REJECTED: begin
				if (!trig_now) begin
					state_d = ST_STANDBY;
				end
			end
			ST_FAILED: begin
				if (!trig_now) begin
					state_d = ST_STANDBY;
				end
			end
			default: state_d = ST_STANDBY;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_STANDBY;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************************
	// Failure trip and lock
	// ****************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= (state_d == ST_FAILED);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q <= 1'b0;
		end else if (state_d == ST_FAILED && state_q == ST_RUNNING) begin
			lock_q <= 1'b1;
		end else if (hmi_ack || sw_ack) begin
			lock_q <= 1'b0;
		end
	end

	assign failure_trip = trip_q;
	assign lock = lock_q;

	// ****************************************************
	// Interrupts
	// ****************************************************
	assign irq_set[`BF_IRQ_FAIL_BIT] = (state_d == ST_FAILED) && (state_q == ST_RUNNING);
	assign irq_set[`BF_IRQ_REJECT_BIT] = (state_d == ST_REJECTED) && (state_q == ST_RUNNING);
	assign irq_set[`BF_IRQ_START_BIT] = start;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (wr_commit && wb_req.adr == `BF_ADR_IRQ_STAT && wb_req.sel[0]) begin
			irq_stat_q <= (irq_stat_q & ~wb_req.dat[`BF_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= `BF_MASK_RST;
		end else if (wr_commit && wb_req.adr == `BF_ADR_IRQ_MASK && wb_req.sel[0]) begin
			irq_mask_q <= wb_req.dat[`BF_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

endmodule : breaker_failure_supervisor
`default_nettype wire

// *** verification/bf_sup_chk.sv ***
// Port assertions for the breaker failure supervisor
`timescale 1ns/1ps
`default_nettype none
`include "bf_cfg.svh"

module bf_sup_chk #(
	parameter int unsigned TICK_CYC = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus
	input wire bf_pkg::wb_req_t wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Relay side
	input wire bf_pkg::relay_in_t relay_in,
	input wire logic hmi_ack,
	input wire logic failure_trip,
	input wire logic lock,
	input wire logic irq
);
	import bf_pkg::*;
	logic req;
	logic trg;
	logic ack_wr;
	assign req = wb_req.cyc && wb_req.stb;
	assign trg = |relay_in[8:3];
	assign ack_wr = req && wb_req.we && wb_req.adr == `BF_ADR_ACK && wb_ack_o;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_bad_adr: assert property (req && !wb_req.we && wb_req.adr == 8'h20 && !wb_ack_o
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_lock_set: assert property ($rose(failure_trip) |-> lock)
		else $error("lock missing at trip");
	a_lock_cause: assert property ($rose(lock) |-> $rose(failure_trip))
		else $error("lock without trip");
	a_lock_holds: assert property (lock && !hmi_ack && !ack_wr |=> lock)
		else $error("lock dropped");
	a_lock_clear: assert property (hmi_ack && !failure_trip ##1 !failure_trip |-> !lock)
		else $error("lock not cleared");
	a_trip_trig: assert property (failure_trip && !trg |=> !failure_trip)
		else $error("trip held without trigger");
	a_trip_closed: assert property ($rose(failure_trip)
		|-> $past(relay_in.current_above || !relay_in.position_open))
		else $error("trip with breaker open");
	a_trip_stays: assert property (failure_trip && |relay_in.extra_trigger_input
		|=> failure_trip) else $error("trip dropped early");
endmodule : bf_sup_chk

bind breaker_failure_supervisor bf_sup_chk #(.TICK_CYC(TICK_CYC)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .relay_in(relay_in), .hmi_ack(hmi_ack),
	.failure_trip(failure_trip), .lock(lock), .irq(irq));

`default_nettype wire

// *** verification/breaker_failure_supervisor_tb_top.sv ***
// Self-checking bench for the breaker failure supervisor
`timescale 1ns/1ps
`default_nettype none
`include "bf_cfg.svh"

module breaker_failure_supervisor_tb_top;
	import bf_pkg::*;
	typedef struct packed {
		logic [1:0] m;
		logic [1:0] c;
		logic [5:0] t;
		logic [1:0] b;
		logic f;
		logic e;
	} row_t;
	localparam int TK = 4;
	// Method, class, triggers, breaker mode, off-frequency, failure
	row_t rows [20] = '{'{0, 0, 6'h20, 0, 0, 0}, '{0, 0, 6'h20, 1, 0, 1}, '{0, 0, 6'h20, 2, 0, 0},
		'{1, 0, 6'h20, 2, 0, 1}, '{1, 0, 6'h20, 3, 0, 0}, '{2, 0, 6'h20, 2, 0, 0},
		'{2, 0, 6'h20, 3, 0, 0}, '{2, 0, 6'h20, 1, 0, 1}, '{0, 0, 6'h20, 1, 1, 0},
		'{2, 0, 6'h20, 2, 1, 1}, '{2, 0, 6'h20, 3, 1, 0}, '{1, 1, 6'h08, 1, 0, 0},
		'{1, 1, 6'h10, 1, 0, 1}, '{1, 2, 6'h08, 1, 0, 1}, '{1, 2, 6'h10, 1, 0, 0},
		'{1, 3, 6'h20, 1, 0, 0}, '{1, 3, 6'h01, 1, 0, 1}, '{1, 3, 6'h02, 1, 0, 1},
		'{1, 3, 6'h04, 1, 0, 1}, '{3, 0, 6'h20, 1, 0, 0}};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	relay_in_t relay_in;
	logic hmi_ack = 1'b0;
	logic failure_trip;
	logic lock;
	logic irq;
	logic [5:0] trig = '0;
	logic [1:0] bmode = '0;
	logic freq = 1'b0;
	logic cur;
	logic pos;
	logic [31:0] rd;
	int fails = 0;
	int check_count = 0;
	int cyc_n = 0;
	int n;
	row_t r;
	assign relay_in = {trig, cur, pos, freq};
	breaker_failure_supervisor #(.TICK_CYC(TK)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .relay_in(relay_in), .hmi_ack(hmi_ack),
		.failure_trip(failure_trip), .lock(lock), .irq(irq));
	breaker_model u_brk (
		.core_clk(core_clk), .rst_n(rst_n), .trip_cmd(|trig), .lock(lock),
		.bmode(bmode), .current_above(cur), .position_open(pos));
	initial begin
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fails++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		if (fails == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
		@(posedge core_clk);
		while (wb_ack_o !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = wb_dat_o;
		wb_req <= '0;
		@(posedge core_clk);
	endtask : wb
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		wb(0, `BF_ADR_CTRL, 0);
		chk("ctrl_rst", 32'h10, rd);
		wb(0, `BF_ADR_TIME, 0);
		chk("time_rst", 32'h64, rd);
		wb(0, `BF_ADR_IRQ_MASK, 0);
		chk("mask_rst", 32'h0, rd);
		wb(1, 8'h20, 32'hFFFF);
		wb(0, 8'h20, 0);
		chk("unmapped", 32'h0, rd);
		wb(1, `BF_ADR_TIME, 3);
		wb(1, `BF_ADR_IRQ_MASK, 1);
		foreach (rows[i]) begin
			r = rows[i];
			wb(1, `BF_ADR_CTRL, {28'h1, r.c, r.m});
			bmode <= r.b;
			freq <= r.f;
			trig <= r.t;
			repeat (30) @(posedge core_clk);
			chk("trip", r.e, failure_trip);
			chk("lock", r.e, lock);
			chk("irq", r.e, irq);
			trig <= '0;
			repeat (3) @(posedge core_clk);
			chk("trip_drop", 0, failure_trip);
			chk("lock_hold", r.e, lock);
			if (i[0]) begin
				hmi_ack <= 1'b1;
				@(posedge core_clk);
				hmi_ack <= 1'b0;
			end else begin
				wb(1, `BF_ADR_ACK, 1);
			end
			wb(1, `BF_ADR_IRQ_STAT, 7);
			chk("lock_clr", 0, lock);
			chk("irq_clr", 0, irq);
		end
		wb(1, `BF_ADR_CTRL, 32'h11);
		bmode <= 2'h1;
		trig <= 6'h20;
		@(posedge core_clk);
		trig <= '0;
		n = 0;
		while (failure_trip !== 1'b1 && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		chk("delay", 1, n >= 3 * TK + 1 && n <= 3 * TK + 3);
		chk("lock_set", 1, lock);
		wb(1, `BF_ADR_IRQ_MASK, 0);
		chk("irq_masked", 0, irq);
		wb(1, `BF_ADR_IRQ_MASK, 1);
		chk("irq_unmask", 1, irq);
		wb(1, `BF_ADR_ACK, 1);
		bmode <= 2'h0;
		trig <= 6'h20;
		repeat (20) @(posedge core_clk);
		wb(0, `BF_ADR_STATUS, 0);
		chk("rejected", 1, rd[1]);
		chk("no_trip", 0, failure_trip);
		trig <= '0;
		repeat (3) @(posedge core_clk);
		wb(0, `BF_ADR_STATUS, 0);
		chk("standby", 0, rd[2:0]);
		wb(0, `BF_ADR_IRQ_STAT, 0);
		chk("irq_stat", 32'h7, rd);
		wb(1, `BF_ADR_IRQ_STAT, 32'h2);
		wb(0, `BF_ADR_IRQ_STAT, 0);
		chk("irq_w1c", 32'h5, rd);
		bmode <= 2'h1;
		trig <= 6'h20;
		repeat (30) @(posedge core_clk);
		chk("retrigger", 1, failure_trip);
		trig <= '0;
		wb(1, `BF_ADR_ACK, 1);
		wb(1, `BF_ADR_CTRL, 32'h10);
		trig <= 6'h20;
		repeat (6) @(posedge core_clk);
		freq <= 1'b1;
		repeat (30) @(posedge core_clk);
		chk("freq_abort", 0, failure_trip);
		freq <= 1'b0;
		trig <= '0;
		wb(1, `BF_ADR_CTRL, 32'h11);
		trig <= 6'h20;
		repeat (30) @(posedge core_clk);
		chk("lock_pre_rst", 1, lock);
		rst_n <= 1'b0;
		trig <= '0;
		@(posedge core_clk);
		chk("rst_trip", 0, failure_trip);
		chk("rst_lock", 0, lock);
		chk("rst_irq", 0, irq);
		rst_n <= 1'b1;
		wb(0, `BF_ADR_IRQ_STAT, 0);
		chk("rst_stat", 0, rd);
		wb(0, `BF_ADR_CTRL, 0);
		chk("rst_ctrl", 32'h10, rd);
		wrap_up();
	end
endmodule : breaker_failure_supervisor_tb_top

`default_nettype wire

// *** verification/breaker_model.sv ***
// Breaker model: phase current and position contacts
`timescale 1ns/1ps
`default_nettype none

module breaker_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Commands
	input wire logic trip_cmd,
	input wire logic lock,
	input wire logic [1:0] bmode,
	// Indications
	output logic current_above,
	output logic position_open
);
	logic [2:0] cnt_q;
	logic done;
	// ****
	// Opens four cycles after trip
	// ****
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 3'h0;
		end else if (!trip_cmd && !lock) begin
			cnt_q <= 3'h0;
		end else if (trip_cmd && cnt_q != 3'h4) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	assign done = cnt_q == 3'h4;
	// Mode 0 opens, 1 stuck, 2 current only, 3 contacts only
	assign current_above = !(done && !bmode[0]);
	assign position_open = done && (bmode[0] == bmode[1]);
endmodule : breaker_model

`default_nettype wire
